// *** rtl/bssp_pkg.sv ***
// Purpose: shared constants for the buffered synchronous serial port
// Assumes: APB register bus with 32-bit data, one aligned word per register
// Notes: fc is the system clock; fs arrives as a one-cycle enable pulse
package bssp_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL_FIRST = 12'h000;
    localparam logic [11:0] OFF_CTRL_SECOND = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_CONFIG = 12'h00c;
    localparam logic [11:0] OFF_BUF_BASE = 12'h020;
    localparam logic [11:0] OFF_BUF_LAST = 12'h03c;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTRL_RUN_BIT = 7;
    localparam int CTRL_ABORT_BIT = 6;
    localparam int CTRL_MODE_LSB = 3;
    localparam int CTRL_SCK_LSB = 0;
    localparam int CTRL2_WORDS_LSB = 0;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_SHIFT_BIT = 1;
    localparam int CFG_PRESCALE_BIT = 0;
    localparam int CFG_SLEEP_BIT = 1;
    // ---------------------------------------------------------------
    // encodings and reset values
    // ---------------------------------------------------------------
    localparam logic [2:0] MODE_TX8 = 3'h0;
    localparam logic [2:0] MODE_TX4 = 3'h2;
    localparam logic [2:0] MODE_TXRX8 = 3'h4;
    localparam logic [2:0] MODE_RX8 = 3'h5;
    localparam logic [2:0] MODE_RX4 = 3'h6;
    localparam logic [2:0] SCK_SLOWEST = 3'h0;
    localparam logic [2:0] SCK_DIV8 = 3'h1;
    localparam logic [2:0] SCK_DIV7 = 3'h2;
    localparam logic [2:0] SCK_DIV6 = 3'h3;
    localparam logic [2:0] SCK_DIV5 = 3'h4;
    localparam logic [2:0] SCK_DIV4 = 3'h5;
    localparam logic [2:0] SCK_EXTERNAL = 3'h7;
    localparam logic [2:0] LAST_BIT_8 = 3'h7;
    localparam logic [2:0] LAST_BIT_4 = 3'h3;
    localparam logic [2:0] RST_CTRL3 = 3'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // ---------------------------------------------------------------
    // clock division: half-period masks of fc/2^n, fs/2^5
    // ---------------------------------------------------------------
    localparam logic [11:0] HALF_MASK_13 = 12'h0fff;
    localparam logic [11:0] HALF_MASK_8 = 12'h007f;
    localparam logic [11:0] HALF_MASK_7 = 12'h003f;
    localparam logic [11:0] HALF_MASK_6 = 12'h001f;
    localparam logic [11:0] HALF_MASK_5 = 12'h000f;
    localparam logic [11:0] HALF_MASK_4 = 12'h0007;
    localparam logic [3:0] LOW_HALF_LAST = 4'hf;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_WAIT
    } bssp_state_type;
endpackage : bssp_pkg

// *** rtl/bssp_top.sv ***
// Purpose: buffered synchronous serial port with eight-entry data buffer
// Assumes: APB slave, zero wait states; serial pins cross into i_clk
// Notes: clock pin is split into input, output and output enable
`timescale 1ns/10ps
`default_nettype none

module bssp_top (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_low_clk_tick,
    input wire logic i_sck,
    output logic o_sck,
    output logic o_sck_oe,
    output logic o_so,
    input wire logic i_si,
    output logic o_transfer_done_irq
);
    import bssp_pkg::*;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    bssp_state_type state;
    logic [2:0] sck_sel;
    logic [2:0] transfer_mode_field;
    logic run_bit;
    logic [2:0] word_code;
    logic low_speed_prescale_select;
    logic sleep_power_modes;
    logic [7:0] data_buffer_entries [0:7];
    logic [11:0] div_cnt;
    logic [3:0] low_cnt;
    logic sck_int;
    logic sck_meta, sck_sync, sck_prev;
    logic si_meta, si_sync;
    logic [2:0] bit_cnt;
    logic [2:0] word_idx;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic serviced;
    logic wrapped;
    logic access, wr_access, rd_access;
    logic buf_hit, reg_hit, ctrl_first_wr;
    logic [2:0] buf_sel;
    logic abort_now, start_now, svc_evt;
    logic ext_clk, mode_rx, mode_tx, nibble;
    logic half_tick, fall_evt, rise_evt;
    logic word_done, batch_end, cancel_rx, store_rx, wait_exit;
    logic [2:0] last_bit;
    logic [2:0] next_idx;
    logic [7:0] next_rx;
    logic [7:0] rx_word;
    logic [31:0] next_rdata;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    assign access = i_psel & i_penable;
    assign wr_access = access & i_pwrite;
    assign rd_access = access & ~i_pwrite;
    assign buf_hit = (i_paddr >= OFF_BUF_BASE) && (i_paddr <= OFF_BUF_LAST);
    assign buf_sel = i_paddr[4:2];
    assign reg_hit = buf_hit || (i_paddr == OFF_CTRL_FIRST) || (i_paddr == OFF_CTRL_SECOND)
        || (i_paddr == OFF_STATUS) || (i_paddr == OFF_CONFIG);
    assign ctrl_first_wr = wr_access && (i_paddr == OFF_CTRL_FIRST);
    assign abort_now = ctrl_first_wr && i_pwdata[CTRL_ABORT_BIT];
    assign start_now = ctrl_first_wr && i_pwdata[CTRL_RUN_BIT] && (state == ST_IDLE)
        && !abort_now;
    assign o_pready = 1'b1;
    assign o_pslverr = access && !reg_hit;

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    assign ext_clk = (sck_sel == SCK_EXTERNAL);
    assign mode_rx = (transfer_mode_field == MODE_RX8) || (transfer_mode_field == MODE_RX4)
        || (transfer_mode_field == MODE_TXRX8);
    assign mode_tx = (transfer_mode_field == MODE_TX8) || (transfer_mode_field == MODE_TX4)
        || (transfer_mode_field == MODE_TXRX8);
    assign nibble = (transfer_mode_field == MODE_TX4) || (transfer_mode_field == MODE_RX4);
    assign last_bit = nibble ? LAST_BIT_4 : LAST_BIT_8;

    // buffer servicing: writes for transmit, reads for receive
    assign svc_evt = buf_hit && ((mode_tx && wr_access) || (mode_rx && rd_access));

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sck_sel <= RST_CTRL3;
            transfer_mode_field <= RST_CTRL3;
            run_bit <= 1'b0;
        end else if (ctrl_first_wr) begin
            sck_sel <= i_pwdata[CTRL_SCK_LSB +: 3];
            transfer_mode_field <= i_pwdata[CTRL_MODE_LSB +: 3];
            run_bit <= i_pwdata[CTRL_RUN_BIT] && !i_pwdata[CTRL_ABORT_BIT];
        end else if (state != ST_IDLE && word_done && cancel_rx) begin
            run_bit <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            word_code <= RST_CTRL3;
        end else if (wr_access && i_paddr == OFF_CTRL_SECOND) begin
            word_code <= i_pwdata[CTRL2_WORDS_LSB +: 3];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            low_speed_prescale_select <= 1'b0;
            sleep_power_modes <= 1'b0;
        end else if (wr_access && i_paddr == OFF_CONFIG) begin
            low_speed_prescale_select <= i_pwdata[CFG_PRESCALE_BIT];
            sleep_power_modes <= i_pwdata[CFG_SLEEP_BIT];
        end
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sck_meta <= 1'b1;
            sck_sync <= 1'b1;
            sck_prev <= 1'b1;
            si_meta <= 1'b0;
            si_sync <= 1'b0;
        end else begin
            sck_meta <= i_sck;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
            si_meta <= i_si;
            si_sync <= si_meta;
        end
    end

    // ---------------------------------------------------------------
    // internal rate generation
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || start_now || wait_exit) begin
            div_cnt <= '0;
            low_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 12'h0001;
            if (i_low_clk_tick) begin
                low_cnt <= low_cnt + 4'h1;
            end
        end
    end

    always_comb begin
        unique case (sck_sel)
            SCK_SLOWEST: begin
                if (low_speed_prescale_select || sleep_power_modes) begin
                    half_tick = i_low_clk_tick && (low_cnt == LOW_HALF_LAST);
                end else begin
                    half_tick = ((div_cnt & HALF_MASK_13) == HALF_MASK_13);
                end
            end
            SCK_DIV8: half_tick = ((div_cnt & HALF_MASK_8) == HALF_MASK_8);
            SCK_DIV7: half_tick = ((div_cnt & HALF_MASK_7) == HALF_MASK_7);
            SCK_DIV6: half_tick = ((div_cnt & HALF_MASK_6) == HALF_MASK_6);
            SCK_DIV5: half_tick = ((div_cnt & HALF_MASK_5) == HALF_MASK_5);
            SCK_DIV4: half_tick = ((div_cnt & HALF_MASK_4) == HALF_MASK_4);
            default: half_tick = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // shift events
    // ---------------------------------------------------------------
    always_comb begin
        if (state != ST_SHIFT) begin
            fall_evt = 1'b0;
            rise_evt = 1'b0;
        end else if (ext_clk) begin
            fall_evt = sck_prev && !sck_sync;
            rise_evt = !sck_prev && sck_sync;
        end else begin
            fall_evt = half_tick && sck_int;
            rise_evt = half_tick && !sck_int;
        end
    end

    assign word_done = rise_evt && (bit_cnt == last_bit);
    assign batch_end = word_done && (word_idx == word_code);
    assign next_idx = batch_end ? 3'h0 : word_idx + 3'h1;
    assign next_rx = {si_sync, rx_shift[7:1]};
    assign rx_word = nibble ? {4'h0, next_rx[7:4]} : next_rx;
    assign cancel_rx = word_done && mode_rx && ext_clk && wrapped && !serviced;
    assign store_rx = word_done && mode_rx && !cancel_rx;
    assign wait_exit = (state == ST_WAIT) && run_bit && serviced;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
        end else if (abort_now) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_now) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (word_done) begin
                        if (cancel_rx || !run_bit) begin
                            state <= ST_IDLE;
                        end else if (batch_end && !ext_clk && !serviced && !svc_evt) begin
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (!run_bit) begin
                        state <= ST_IDLE;
                    end else if (serviced) begin
                        state <= ST_SHIFT;
                    end
                end
            endcase
        end
    end

    // servicing flag: a new access wins over the clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            serviced <= 1'b0;
        end else if (svc_evt) begin
            serviced <= 1'b1;
        end else if (start_now || batch_end || wait_exit || abort_now) begin
            serviced <= 1'b0;
        end
    end

    // external-clock batch wrapped without being serviced
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || start_now || abort_now) begin
            wrapped <= 1'b0;
        end else if (svc_evt) begin
            wrapped <= 1'b0;
        end else if (batch_end) begin
            wrapped <= ext_clk && !serviced;
        end else if (word_done) begin
            wrapped <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // counters and shift registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || start_now) begin
            bit_cnt <= 3'h0;
            word_idx <= 3'h0;
        end else if (word_done) begin
            bit_cnt <= 3'h0;
            word_idx <= next_idx;
        end else if (rise_evt) begin
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            tx_shift <= RST_BYTE;
            o_so <= 1'b1;
        end else if (start_now || wait_exit) begin
            tx_shift <= data_buffer_entries[0];
        end else if (word_done) begin
            tx_shift <= data_buffer_entries[next_idx];
        end else if (fall_evt) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            o_so <= mode_tx ? tx_shift[0] : 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || start_now) begin
            rx_shift <= RST_BYTE;
        end else if (rise_evt) begin
            rx_shift <= next_rx;
        end
    end

    // ---------------------------------------------------------------
    // serial clock pin
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sck_int <= 1'b1;
        end else if (state != ST_SHIFT || start_now) begin
            sck_int <= 1'b1;
        end else if (!ext_clk && half_tick) begin
            sck_int <= ~sck_int;
        end
    end

    assign o_sck = sck_int;
    assign o_sck_oe = !ext_clk;

    // ---------------------------------------------------------------
    // data buffer
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 8; i++) begin
                data_buffer_entries[i] <= RST_BYTE;
            end
        end else if (ctrl_first_wr && i_pwdata[CTRL_MODE_LSB +: 3] != transfer_mode_field) begin
            for (int i = 0; i < 8; i++) begin
                data_buffer_entries[i] <= RST_BYTE;
            end
        end else begin
            if (store_rx && state == ST_SHIFT) begin
                data_buffer_entries[word_idx] <= rx_word;
            end
            if (wr_access && buf_hit) begin
                data_buffer_entries[buf_sel] <= i_pwdata[7:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // transfer interrupt
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_transfer_done_irq <= 1'b0;
        end else begin
            o_transfer_done_irq <= batch_end && !cancel_rx && !abort_now;
        end
    end

    // ---------------------------------------------------------------
    // read data, captured in the setup phase
    // ---------------------------------------------------------------
    always_comb begin
        next_rdata = RST_WORD;
        if (buf_hit) begin
            next_rdata[7:0] = data_buffer_entries[buf_sel];
        end else if (i_paddr == OFF_STATUS) begin
            next_rdata[STAT_ACTIVE_BIT] = (state != ST_IDLE);
            next_rdata[STAT_SHIFT_BIT] = (state == ST_SHIFT);
        end else if (i_paddr == OFF_CONFIG) begin
            next_rdata[CFG_PRESCALE_BIT] = low_speed_prescale_select;
            next_rdata[CFG_SLEEP_BIT] = sleep_power_modes;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_prdata <= RST_WORD;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= next_rdata;
        end
    end
endmodule : bssp_top

`default_nettype wire

// *** dv/bssp_properties.sv ***
// Purpose: port checker for the buffered serial port
// Assumes: sees the top ports only
// Notes: clock select is tracked from bus writes
`timescale 1ns/10ps
`default_nettype none
module bssp_properties (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_sck,
    input wire logic o_sck_oe,
    input wire logic o_so,
    input wire logic o_transfer_done_irq
);
    import bssp_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic wr_ctl;
    logic [2:0] ck;
    logic [11:0] low_cnt;
    assign wr_ctl = i_psel && i_penable && i_pwrite && i_paddr == OFF_CTRL_FIRST;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) ck <= SCK_SLOWEST;
        else if (wr_ctl) ck <= i_pwdata[CTRL_SCK_LSB +: 3];
    end
    always_ff @(posedge i_clk) begin
        low_cnt <= o_sck ? 12'h000 : low_cnt + 12'h001;
    end
    a_sck_source: assert property (o_sck_oe == (ck != SCK_EXTERNAL))
        else $error("clock pin drive differs from clock select");
    a_start_high: assert property (
        wr_ctl && i_pwdata[CTRL_RUN_BIT] && !i_pwdata[CTRL_ABORT_BIT]
        && i_pwdata[2:0] != SCK_EXTERNAL |=> o_sck)
        else $error("clock pin not high at transfer start");
    a_sck_rate: assert property (
        $rose(o_sck) && o_sck_oe && ck >= SCK_DIV8 && ck <= SCK_DIV4
        |-> low_cnt == (12'h001 << (4'h8 - 4'(ck))))
        else $error("internal clock low phase has wrong length");
    a_tx_on_fall: assert property (
        $changed(o_so) && o_sck_oe && !$past(wr_ctl) && !$past(wr_ctl, 2) |-> $fell(o_sck))
        else $error("serial out changed away from a falling clock");
    a_done_pulse: assert property (o_transfer_done_irq |=> !o_transfer_done_irq)
        else $error("done interrupt longer than one cycle");
    a_done_after_rise: assert property (
        o_transfer_done_irq && o_sck_oe |-> $rose(o_sck))
        else $error("done interrupt not right after a rising clock");
    a_ready_high: assert property (o_pready)
        else $error("bus slave inserted a wait state");
    a_bad_addr: assert property (i_psel && i_penable && i_paddr >= 12'h040 |-> o_pslverr)
        else $error("unmapped access not flagged");
endmodule : bssp_properties
bind bssp_top bssp_properties u_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
    .o_so(o_so), .o_transfer_done_irq(o_transfer_done_irq));
`default_nettype wire

// *** dv/bssp_peer.sv ***
// Purpose: far-end serial partner
// Assumes: resolved clock pin, lsb first both ways
// Notes: drives the clock only while pulses remain
`timescale 1ns/10ps
`default_nettype none
module bssp_peer (
    input wire logic i_clk,
    input wire logic i_pin_sck,
    input wire logic i_so,
    input wire logic i_load,
    input wire logic [63:0] i_tx,
    input wire logic [6:0] i_pulses,
    output logic o_si,
    output logic o_sck,
    output logic [63:0] o_cap
);
    logic [63:0] tx = 64'h0;
    logic [6:0] left = 7'h00;
    logic [2:0] div = 3'h0;
    logic last = 1'b1;
    initial begin
        o_si = 1'b1;
        o_sck = 1'b1;
        o_cap = 64'h0;
    end
    always @(posedge i_clk) begin
        last <= i_pin_sck;
        if (i_load) begin
            tx <= i_tx;
            left <= i_pulses;
            o_cap <= 64'h0;
            div <= 3'h0;
        end else begin
            if (i_pin_sck && !last) o_cap <= {i_so, o_cap[63:1]};
            if (!i_pin_sck && last) o_si <= tx[0];
            if (!i_pin_sck && last) tx <= {~tx[0], tx[63:1]};
            if (left != 7'h00) div <= div + 3'h1;
            if (left != 7'h00 && div == 3'h7) begin
                o_sck <= ~o_sck;
                left <= o_sck ? left : left - 7'h01;
            end
        end
    end
endmodule : bssp_peer
`default_nettype wire

// *** dv/testbench.sv ***
// Purpose: self-checking bench for the buffered serial port
// Assumes: zero-wait bus slave, peer model on the serial pins
// Notes: each transfer is ended by abort once its batch is done
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import bssp_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rq;
    logic pready, pslverr, re, sck_o, sck_oe, so, si, peer_sck, irq;
    logic ld = 1'b0;
    logic [63:0] ptx = 64'h0;
    logic [63:0] cap;
    logic [6:0] pulses = 7'h00;
    logic low_tick = 1'b0;
    wire logic pin_sck = sck_oe ? sck_o : peer_sck;
    int fails = 0;
    int checks = 0;
    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) low_tick <= ~low_tick;
    bssp_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_low_clk_tick(low_tick), .i_sck(pin_sck),
        .o_sck(sck_o), .o_sck_oe(sck_oe), .o_so(so), .i_si(si), .o_transfer_done_irq(irq));
    bssp_peer peer (.i_clk(i_clk), .i_pin_sck(pin_sck), .i_so(so), .i_load(ld), .i_tx(ptx),
        .i_pulses(pulses), .o_si(si), .o_sck(peer_sck), .o_cap(cap));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) fails++;
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask : apb
    function automatic logic [31:0] ctl(input logic r, input logic b, input logic [2:0] m,
        input logic [2:0] c);
        return {24'h00_0000, r, b, m, c};
    endfunction : ctl
    function automatic logic [31:0] field(input logic [63:0] v, input int sh, input int w);
        return {24'h00_0000, 8'(v >> sh) & (w == 4 ? 8'h0f : 8'hff)};
    endfunction : field
    task automatic xfer(input logic [2:0] md, input logic [2:0] c, input int n);
        logic [7:0] bv [8];
        int w;
        int t;
        logic tx;
        logic rx;
        w = (md == MODE_TX4 || md == MODE_RX4) ? 4 : 8;
        tx = md == MODE_TX8 || md == MODE_TX4 || md == MODE_TXRX8;
        rx = md == MODE_TXRX8 || md == MODE_RX8 || md == MODE_RX4;
        apb(1'b1, OFF_CTRL_FIRST, ctl(1'b0, 1'b1, md, c));
        for (int k = 0; k < 8; k++) begin
            bv[k] = 8'($urandom);
            apb(1'b1, OFF_BUF_BASE + 12'(4 * k), {24'h00_0000, bv[k]});
        end
        apb(1'b1, OFF_CTRL_SECOND, 32'(n - 1));
        apb(1'b1, OFF_CTRL_FIRST, ctl(1'b1, 1'b0, md, c));
        ptx <= {$urandom, $urandom};
        pulses <= (c == SCK_EXTERNAL) ? 7'(n * w) : 7'h00;
        ld <= 1'b1;
        @(posedge i_clk);
        ld <= 1'b0;
        t = 0;
        while (irq !== 1'b1 && t < 20000) begin
            @(posedge i_clk);
            t++;
        end
        chk({31'h0, irq}, 32'h1);
        repeat (100) @(posedge i_clk);
        chk({31'h0, sck_o | ~sck_oe}, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk(rq & 32'h1, 32'h1);
        apb(1'b1, OFF_CTRL_FIRST, ctl(1'b0, 1'b1, md, c));
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk(rq & 32'h1, 32'h0);
        for (int k = 0; k < n; k++) begin
            if (tx) chk(field(cap, 64 - n * w + w * k, w), field(64'(bv[k]), 0, w));
            if (rx) apb(1'b0, OFF_BUF_BASE + 12'(4 * k), 32'h0000_0000);
            if (rx) chk(rq, field(ptx, w * k, w));
        end
        $display("test done mode %h clock %h words %0d", md, c, n);
    endtask : xfer
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (80000) @(posedge i_clk);
        fails++;
        end_sim;
    end
    initial begin
        logic [2:0] c;
        logic [2:0] modes [5];
        modes = '{MODE_TX8, MODE_TX4, MODE_TXRX8, MODE_RX8, MODE_RX4};
        void'($urandom(32'h2471_34c3));
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk(rq, 32'h0);
        apb(1'b1, OFF_BUF_BASE, 32'h0000_005a);
        apb(1'b1, OFF_CTRL_FIRST, ctl(1'b0, 1'b1, MODE_RX8, SCK_DIV4));
        apb(1'b0, OFF_BUF_BASE, 32'h0000_0000);
        chk(rq, 32'h0);
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk({31'h0, re}, 32'h1);
        $display("test done registers");
        for (int it = 0; it < 3; it++) begin
            foreach (modes[m]) begin
                c = 3'(3 + $urandom_range(2, 0));
                c = it == 1 ? SCK_EXTERNAL : (it == 0 ? SCK_DIV4 : c);
                xfer(modes[m], c, it == 0 ? 8 : $urandom_range(8, 1));
            end
        end
        xfer(MODE_TX8, SCK_DIV7, 2);
        xfer(MODE_RX4, SCK_DIV8, 2);
        apb(1'b1, OFF_CONFIG, 32'h0000_0001);
        apb(1'b0, OFF_CONFIG, 32'h0000_0000);
        chk(rq, 32'h0000_0001);
        xfer(MODE_TX4, SCK_SLOWEST, 1);
        end_sim;
    end
endmodule : testbench
`default_nettype wire
